//--- include/nbm_pkg.sv
// package for the nand power-up and bad-block manager
package nbm_pkg;
  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned POR_WAIT_US    = 1000;
  localparam int unsigned POR_WAIT_CYC   = POR_WAIT_US * (CLK_HZ / 1_000_000);
  localparam logic [7:0]  ERASED_BYTE    = 8'hFF;
  localparam int unsigned BLOCKS_LOW     = 2048;
  localparam int unsigned BLOCKS_HIGH    = 4096;
  localparam int unsigned LAST_BLOCK_LOW = 2047;
  localparam int unsigned LAST_BLOCK_HI  = 4095;
  localparam int unsigned MIN_GOOD_LOW   = 2008;
  localparam int unsigned MIN_GOOD_HIGH  = 4016;
  localparam int unsigned SYNC_RST_VAL   = 0;
  localparam logic [1:0]  OP_READ        = 2'h0;
  localparam logic [1:0]  OP_PROGRAM     = 2'h1;
  localparam logic [1:0]  OP_ERASE       = 2'h2;
  typedef enum logic [2:0] {
    NBM_POWER  = 3'b000,
    NBM_WAIT   = 3'b001,
    NBM_SCAN   = 3'b010,
    NBM_SCANWT = 3'b011,
    NBM_READY  = 3'b100,
    NBM_OPWT   = 3'b101
  } nbm_state_e;
endpackage : nbm_pkg

//--- rtl/nbm_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module nbm_sync (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic async_in,
  output logic      level_out
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic lvl_reg;
  logic lvl_next;

  always_comb begin
    lvl_next = lvl_reg;
    if (s2_reg == s3_reg) begin
      lvl_next = s3_reg;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_reg  <= 1'b0;
      s2_reg  <= 1'b0;
      s3_reg  <= 1'b0;
      lvl_reg <= 1'b0;
    end else begin
      s1_reg  <= async_in;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      lvl_reg <= lvl_next;
    end
  end

  assign level_out = lvl_reg;
endmodule : nbm_sync

//--- rtl/nbm_host.sv
// host-side power-up sequencer and bad-block table keeper
// Function
// - no command is issued while the device power-on reset runs
// - reset done when ready_busy_n returns high or 1 ms after supply valid
// - write_protect_n held low during power-up and power-down
// - scan first spare byte of pages one and two of every block, mark non-FFh bad
// - marker scan completes before any erase is allowed
// - bad blocks are never erased and damaged blocks are retired
// - build the bad-block table once and consult it during operation
// - after erase check status; failure marks the block bad
// - after program check status; failure marks the block for replacement
// - program failure reported so data can be rewritten elsewhere
`timescale 1ns/1ps
module nbm_host
  import nbm_pkg::*;
#(
  parameter int unsigned BLOCK_BITS = 12,
  parameter int unsigned POR_CYCLES = POR_WAIT_CYC
) (
  input  wire logic                  clk_in,
  input  wire logic                  rst_in,
  input  wire logic                  supply_ok_in,
  input  wire logic                  ready_busy_n_in,
  output logic                       write_protect_n_out,
  input  wire logic                  high_density_in,
  output logic                       spare_rd_req_out,
  output logic [BLOCK_BITS-1:0]      spare_rd_block_out,
  output logic                       spare_rd_page_out,
  input  wire logic                  spare_rd_done_in,
  input  wire logic [7:0]            spare_rd_byte_in,
  input  wire logic                  op_req_in,
  input  wire logic [1:0]            op_code_in,
  input  wire logic [BLOCK_BITS-1:0] op_block_in,
  output logic                       op_grant_out,
  output logic                       op_refused_out,
  input  wire logic                  op_done_in,
  input  wire logic                  op_fail_in,
  output logic                       dev_cmd_en_out,
  output logic                       op_start_out,
  output logic                       prog_fail_out,
  output logic                       ready_out,
  output logic [BLOCK_BITS:0]        bad_count_out,
  output logic                       too_many_bad_out
);
  localparam int unsigned NBLK = 1 << BLOCK_BITS;
  localparam int unsigned CW   = $clog2(POR_CYCLES + 1);
  initial begin
    if (BLOCK_BITS < 11 || BLOCK_BITS > 12) $error("nbm_host: BLOCK_BITS must be 11 or 12");
    if (POR_CYCLES < 1) $error("nbm_host: POR_CYCLES must be at least 1");
  end

  logic rb_sync;
  nbm_sync u_rb_sync (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .async_in (ready_busy_n_in),
    .level_out(rb_sync)
  );
  logic sup_sync;
  nbm_sync u_sup_sync (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .async_in (supply_ok_in),
    .level_out(sup_sync)
  );

  logic bad_tbl [NBLK];
  nbm_state_e              state_reg,  state_next;
  logic [CW-1:0]           cnt_reg,    cnt_next;
  logic [BLOCK_BITS-1:0]   blk_reg,    blk_next;
  logic                    page_reg,   page_next;
  logic                    wp_n_reg,   wp_n_next;
  logic                    req_reg,    req_next;
  logic                    grant_reg,  grant_next;
  logic                    refuse_reg, refuse_next;
  logic                    start_reg,  start_next;
  logic                    pfail_reg,  pfail_next;
  logic                    rdy_reg,    rdy_next;
  logic                    cmd_reg,    cmd_next;
  logic [BLOCK_BITS:0]     nbad_reg,   nbad_next;
  logic [1:0]              opc_reg,    opc_next;
  logic [BLOCK_BITS-1:0]   opb_reg,    opb_next;
  logic                    mark_en;
  logic [BLOCK_BITS-1:0]   mark_blk;
  logic [BLOCK_BITS-1:0]   last_blk;
  logic                    is_last;
  logic                    por_done;

  always_comb begin
    last_blk = high_density_in ? BLOCK_BITS'(LAST_BLOCK_HI) : BLOCK_BITS'(LAST_BLOCK_LOW);
    is_last  = (blk_reg == last_blk);
    por_done = rb_sync || (cnt_reg == CW'(POR_CYCLES));
  end

  always_comb begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    blk_next    = blk_reg;
    page_next   = page_reg;
    wp_n_next   = wp_n_reg;
    req_next    = 1'b0;
    grant_next  = 1'b0;
    refuse_next = 1'b0;
    start_next  = 1'b0;
    pfail_next  = 1'b0;
    rdy_next    = rdy_reg;
    cmd_next    = cmd_reg;
    nbad_next   = nbad_reg;
    opc_next    = opc_reg;
    opb_next    = opb_reg;
    mark_en     = 1'b0;
    mark_blk    = blk_reg;
    if (!sup_sync) begin
      // supply lost or ramping: protect data and restart from scratch
      state_next = NBM_POWER;
      wp_n_next  = 1'b0;
      cmd_next   = 1'b0;
      rdy_next   = 1'b0;
      cnt_next   = '0;
    end else begin
      unique case (state_reg)
        NBM_POWER: begin
          cnt_next   = '0;
          state_next = NBM_WAIT;
        end
        NBM_WAIT: begin
          if (cnt_reg != CW'(POR_CYCLES)) begin
            cnt_next = cnt_reg + CW'(1);
          end
          if (por_done && cnt_reg != '0) begin
            cmd_next   = 1'b1;
            wp_n_next  = 1'b1;
            blk_next   = '0;
            page_next  = 1'b0;
            nbad_next  = '0;
            state_next = NBM_SCAN;
          end
        end
        NBM_SCAN: begin
          req_next   = 1'b1;
          state_next = NBM_SCANWT;
        end
        NBM_SCANWT: begin
          if (spare_rd_done_in) begin
            if (spare_rd_byte_in != ERASED_BYTE) begin
              mark_en   = 1'b1;
              nbad_next = nbad_reg + (BLOCK_BITS+1)'(1);
            end
            if (spare_rd_byte_in != ERASED_BYTE || page_reg) begin
              page_next = 1'b0;
              if (is_last) begin
                rdy_next   = 1'b1;
                state_next = NBM_READY;
              end else begin
                blk_next   = blk_reg + BLOCK_BITS'(1);
                state_next = NBM_SCAN;
              end
            end else begin
              page_next  = 1'b1;
              state_next = NBM_SCAN;
            end
          end
        end
        NBM_READY: begin
          if (op_req_in) begin
            opc_next = op_code_in;
            opb_next = op_block_in;
            if (bad_tbl[op_block_in]) begin
              refuse_next = 1'b1;
            end else begin
              grant_next = 1'b1;
              start_next = 1'b1;
              state_next = NBM_OPWT;
            end
          end
        end
        NBM_OPWT: begin
          if (op_done_in) begin
            // read failures go to the ecc path, not the table
            if (op_fail_in && opc_reg != OP_READ) begin
              mark_en   = 1'b1;
              mark_blk  = opb_reg;
              nbad_next = nbad_reg + (BLOCK_BITS+1)'(1);
              pfail_next = (opc_reg == OP_PROGRAM);
            end
            state_next = NBM_READY;
          end
        end
        default: state_next = NBM_POWER;
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg  <= NBM_POWER;
      cnt_reg    <= '0;
      blk_reg    <= '0;
      page_reg   <= 1'b0;
      wp_n_reg   <= 1'b0;
      req_reg    <= 1'b0;
      grant_reg  <= 1'b0;
      refuse_reg <= 1'b0;
      start_reg  <= 1'b0;
      pfail_reg  <= 1'b0;
      rdy_reg    <= 1'b0;
      cmd_reg    <= 1'b0;
      nbad_reg   <= '0;
      opc_reg    <= OP_READ;
      opb_reg    <= '0;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      blk_reg    <= blk_next;
      page_reg   <= page_next;
      wp_n_reg   <= wp_n_next;
      req_reg    <= req_next;
      grant_reg  <= grant_next;
      refuse_reg <= refuse_next;
      start_reg  <= start_next;
      pfail_reg  <= pfail_next;
      rdy_reg    <= rdy_next;
      cmd_reg    <= cmd_next;
      nbad_reg   <= nbad_next;
      opc_reg    <= opc_next;
      opb_reg    <= opb_next;
    end
  end

  // table has no reset; scan rewrites entries up to last_blk before use, so with 12 block bits in low density entries above 2047 stay unwritten
  always_ff @(posedge clk_in) begin
    if (state_reg == NBM_SCAN && !page_reg) begin
      bad_tbl[blk_reg] <= 1'b0;
    end else if (mark_en) begin
      bad_tbl[mark_blk] <= 1'b1;
    end
  end

  logic too_many_reg;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      too_many_reg <= 1'b0;
    end else begin
      too_many_reg <= high_density_in ? (nbad_reg > (BLOCK_BITS+1)'(BLOCKS_HIGH - MIN_GOOD_HIGH))
                                      : (nbad_reg > (BLOCK_BITS+1)'(BLOCKS_LOW - MIN_GOOD_LOW));
    end
  end

  assign write_protect_n_out = wp_n_reg;
  assign spare_rd_req_out    = req_reg;
  assign spare_rd_block_out  = blk_reg;
  assign spare_rd_page_out   = page_reg;
  assign op_grant_out        = grant_reg;
  assign op_refused_out      = refuse_reg;
  assign op_start_out        = start_reg;
  assign prog_fail_out       = pfail_reg;
  assign ready_out           = rdy_reg;
  assign dev_cmd_en_out      = cmd_reg;
  assign bad_count_out       = nbad_reg;
  assign too_many_bad_out    = too_many_reg;

  sequence s_scan_done;
    state_reg == NBM_SCANWT && spare_rd_done_in && is_last && (spare_rd_byte_in != ERASED_BYTE || page_reg);
  endsequence

  a_no_cmd_in_por: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_reg inside {NBM_POWER, NBM_WAIT}) |-> !req_reg && !start_reg)
    else $error("request issued during power-on reset");
  a_wp_low_powerup: assert property (@(posedge clk_in) disable iff (rst_in)
    !sup_sync |=> !wp_n_reg)
    else $error("write protect not low while supply invalid");
  a_por_wait_bound: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_reg == NBM_WAIT && cnt_reg == CW'(POR_CYCLES) && sup_sync) |=> state_reg == NBM_SCAN)
    else $error("power-on wait not ended after timeout");
  a_bad_marked: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_reg == NBM_SCANWT && spare_rd_done_in && spare_rd_byte_in != ERASED_BYTE && sup_sync)
      |=> nbad_reg == $past(nbad_reg) + (BLOCK_BITS+1)'(1))
    else $error("non-erased marker not counted");
  a_no_erase_before: assert property (@(posedge clk_in) disable iff (rst_in)
    start_reg |-> rdy_reg)
    else $error("operation started before scan complete");
  a_ready_after_scan: assert property (@(posedge clk_in) disable iff (rst_in)
    (s_scan_done and sup_sync) |=> rdy_reg && state_reg == NBM_READY)
    else $error("ready not raised after last block");
  a_bad_refused: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_reg == NBM_READY && op_req_in && bad_tbl[op_block_in] && sup_sync) |=> refuse_reg && !start_reg)
    else $error("operation on bad block not refused");
  a_erase_fail_mark: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_reg == NBM_OPWT && op_done_in && op_fail_in && opc_reg == OP_ERASE && sup_sync)
      |=> ##1 bad_tbl[$past(opb_reg, 2)])
    else $error("failed erase block not recorded");
  a_prog_fail_flag: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_reg == NBM_OPWT && op_done_in && op_fail_in && opc_reg == OP_PROGRAM && sup_sync) |=> prog_fail_out)
    else $error("program failure not reported");
endmodule : nbm_host

//--- tb/nbm_dev_model.sv
// behavioural flash device: power-on reset, marker reads and operations
`timescale 1ns/1ps
module nbm_dev_model (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        supply_ok_in,
  input  wire logic        write_protect_n_in,
  input  wire logic [7:0]  por_len_in,
  input  wire logic        spare_rd_req_in,
  input  wire logic [10:0] spare_rd_block_in,
  input  wire logic        spare_rd_page_in,
  input  wire logic        op_start_in,
  input  wire logic        fail_cmd_in,
  output logic             rb_oe_n_out,
  output logic             por_busy_out,
  output logic             spare_rd_done_out,
  output logic [7:0]       spare_rd_byte_out,
  output logic             op_done_out,
  output logic             op_fail_out
);
  int         seed = 73;
  int         por_cnt, rd_cnt, op_cnt;
  logic       sup_q, fail_q;
  logic [7:0] mark;
  assign por_busy_out = !supply_ok_in || por_cnt != 0;
  assign rb_oe_n_out  = !(por_busy_out || op_cnt != 0);
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      por_cnt = 0;
      rd_cnt = 0;
      op_cnt = 0;
      sup_q = 1'b0;
      fail_q = 1'b0;
      mark = 8'hFF;
      spare_rd_done_out <= 1'b0;
      spare_rd_byte_out <= 8'h00;
      op_done_out <= 1'b0;
      op_fail_out <= 1'b0;
    end else begin
      spare_rd_done_out <= 1'b0;
      op_done_out <= 1'b0;
      op_fail_out <= ~op_fail_out;
      // released data lines never hold the last byte
      spare_rd_byte_out <= ~spare_rd_byte_out;
      if (supply_ok_in && !sup_q) por_cnt = por_len_in;
      else if (por_cnt != 0) por_cnt--;
      sup_q = supply_ok_in;
      if (spare_rd_req_in && !por_busy_out) begin
        rd_cnt = 1 + ($random(seed) & 3);
        mark = 8'hFF;
        if (!spare_rd_page_in && spare_rd_block_in % 97 == 5) mark = 8'h00;
        if (spare_rd_page_in && spare_rd_block_in % 131 == 7) mark = 8'h5A;
      end else if (rd_cnt == 1) begin
        rd_cnt = 0;
        spare_rd_done_out <= 1'b1;
        spare_rd_byte_out <= mark;
      end else if (rd_cnt != 0) rd_cnt--;
      if (op_start_in && !por_busy_out) begin
        // long enough that a write-protect drop lands mid-operation
        op_cnt = 8 + ($random(seed) & 3);
        fail_q = fail_cmd_in;
      end else if (!write_protect_n_in) op_cnt = 0;
      else if (op_cnt == 1) begin
        op_cnt = 0;
        op_done_out <= 1'b1;
        op_fail_out <= fail_q;
      end else if (op_cnt != 0) op_cnt--;
    end
  end
endmodule : nbm_dev_model

//--- tb/testbench.sv
// self-checking bench for the nand power-up and bad-block manager
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    err_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
  end \
end
module testbench;
  import nbm_pkg::*;
  logic        clk_in, rst_in, supply_ok_in, op_req_in, fail_cmd, exp_pg, rb_hold;
  logic        write_protect_n_out, spare_rd_req_out, spare_rd_page_out, op_grant_out, op_refused_out;
  logic        dev_cmd_en_out, op_start_out, prog_fail_out, ready_out, too_many_bad_out;
  logic        rb_oe_n, por_busy, rd_done, op_done, op_fail;
  logic [1:0]  op_code_in;
  logic [7:0]  por_len, rd_byte;
  logic [10:0] op_block_in, spare_rd_block_out, exp_blk;
  logic [11:0] bad_count_out;
  logic        bad_tab [BLOCKS_LOW];
  int          err_count, total_checks, seed, cyc, lowcnt, exp_bad, rv;
  // open-drain ready/busy with pull-up; rb_hold is a second device pulling it low
  wire         ready_busy_n = (rb_oe_n && !rb_hold) ? 1'b1 : 1'b0;

  nbm_host #(.BLOCK_BITS(11), .POR_CYCLES(10)) DUT (
    .clk_in(clk_in), .rst_in(rst_in), .supply_ok_in(supply_ok_in), .ready_busy_n_in(ready_busy_n),
    .write_protect_n_out(write_protect_n_out), .high_density_in(1'b0), .spare_rd_req_out(spare_rd_req_out),
    .spare_rd_block_out(spare_rd_block_out), .spare_rd_page_out(spare_rd_page_out),
    .spare_rd_done_in(rd_done), .spare_rd_byte_in(rd_byte), .op_req_in(op_req_in), .op_code_in(op_code_in),
    .op_block_in(op_block_in), .op_grant_out(op_grant_out), .op_refused_out(op_refused_out),
    .op_done_in(op_done), .op_fail_in(op_fail), .dev_cmd_en_out(dev_cmd_en_out), .op_start_out(op_start_out),
    .prog_fail_out(prog_fail_out), .ready_out(ready_out), .bad_count_out(bad_count_out),
    .too_many_bad_out(too_many_bad_out));
  nbm_dev_model dev (
    .clk_in(clk_in), .rst_in(rst_in), .supply_ok_in(supply_ok_in), .write_protect_n_in(write_protect_n_out),
    .por_len_in(por_len), .spare_rd_req_in(spare_rd_req_out), .spare_rd_block_in(spare_rd_block_out),
    .spare_rd_page_in(spare_rd_page_out), .op_start_in(op_start_out), .fail_cmd_in(fail_cmd),
    .rb_oe_n_out(rb_oe_n), .por_busy_out(por_busy), .spare_rd_done_out(rd_done), .spare_rd_byte_out(rd_byte),
    .op_done_out(op_done), .op_fail_out(op_fail));

  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim

  task automatic step;
    @(posedge clk_in);
    #1;
  endtask : step

  task automatic load_table;
    exp_bad = 0;
    for (int b = 0; b < BLOCKS_LOW; b++) begin
      bad_tab[b] = (b % 97 == 5) || (b % 131 == 7);
      exp_bad += bad_tab[b];
    end
  endtask : load_table

  // two scans of 2048 blocks dominate the run
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 90000) begin
      err_count++;
      end_sim();
    end
  end

  always @(negedge clk_in) begin
    lowcnt = supply_ok_in ? 0 : lowcnt + 1;
    if (lowcnt > 5) `CHK({write_protect_n_out, dev_cmd_en_out}, 2'b00)
    if (spare_rd_req_out || op_start_out) `CHK(por_busy, 1'b0)
    if (spare_rd_req_out) begin
      `CHK({spare_rd_block_out, spare_rd_page_out}, {exp_blk, exp_pg})
      // page one is skipped once page zero already marks the block
      if (exp_pg || exp_blk % 97 == 5) begin
        exp_blk = exp_blk + 11'h001;
        exp_pg = 1'b0;
      end else exp_pg = 1'b1;
    end
  end

  task automatic wait_ready;
    int n;
    for (n = 0; n < 40000 && ready_out !== 1'b1; n++) step();
    `CHK({ready_out, dev_cmd_en_out, write_protect_n_out}, 3'b111)
    `CHK(bad_count_out, 12'(exp_bad))
    `CHK(too_many_bad_out, 1'b0)
  endtask : wait_ready

  task automatic do_op(input logic [1:0] c, input logic [10:0] b, input logic f);
    logic g, r, pf;
    int   n;
    g = 1'b0;
    r = 1'b0;
    pf = 1'b0;
    op_code_in = c;
    op_block_in = b;
    fail_cmd = f;
    op_req_in = 1'b1;
    for (n = 0; n < 6 && !(g || r); n++) begin
      step();
      g = op_grant_out;
      r = op_refused_out;
    end
    `CHK({g, r, op_start_out}, {!bad_tab[b], bad_tab[b], !bad_tab[b]})
    op_req_in = 1'b0;
    step();
    if (g) begin
      for (n = 0; n < 16 && op_done !== 1'b1; n++) step();
      `CHK(op_done, 1'b1)
      for (n = 0; n < 3; n++) begin
        step();
        pf = pf | prog_fail_out;
      end
      `CHK(pf, f && c == OP_PROGRAM)
      if (f && c != OP_READ) begin
        bad_tab[b] = 1'b1;
        exp_bad++;
      end
    end
    `CHK(bad_count_out, 12'(exp_bad))
    `CHK(too_many_bad_out, exp_bad > BLOCKS_LOW - MIN_GOOD_LOW)
  endtask : do_op

  initial begin
    int b;
    seed = 73;
    {err_count, total_checks, cyc, lowcnt} = '0;
    {exp_blk, exp_pg, fail_cmd, rb_hold} = '0;
    {rst_in, supply_ok_in, op_req_in} = 3'b100;
    op_code_in = OP_ERASE;
    op_block_in = 11'h005;
    por_len = 8'h04;
    load_table();
    repeat (20) @(posedge clk_in);
    #1 rst_in = 1'b0;
    repeat (10) step();
    supply_ok_in = 1'b1;
    op_req_in = 1'b1;
    for (b = 0; b < 40; b++) begin
      step();
      `CHK(op_grant_out, 1'b0)
    end
    op_req_in = 1'b0;
    wait_ready();
    do_op(OP_PROGRAM, 11'h7FF, 1'b1);
    do_op(OP_PROGRAM, 11'h7FF, 1'b0);
    do_op(OP_READ, 11'h001, 1'b1);
    do_op(OP_ERASE, 11'h000, 1'b1);
    for (int i = 0; i < 48; i++) begin
      rv = $random(seed);
      do_op(rv[1:0] == 2'h3 ? OP_ERASE : rv[1:0], i % 4 == 0 ? 11'(97 * (i % 21) + 5) : rv[12:2], rv[15:14] == 2'h0);
    end
    for (b = 2; bad_tab[b]; b++);
    op_code_in = OP_PROGRAM;
    op_block_in = 11'(b);
    op_req_in = 1'b1;
    for (int n = 0; n < 6 && op_grant_out !== 1'b1; n++) step();
    `CHK(op_start_out, 1'b1)
    op_req_in = 1'b0;
    // let the device take the start before supply falls
    step();
    supply_ok_in = 1'b0;
    for (int n = 0; n < 12; n++) begin
      step();
      `CHK(op_done, 1'b0)
    end
    `CHK({ready_out, write_protect_n_out}, 2'b00)
    load_table();
    por_len = 8'h09;
    // busy line held low, so only the wait can end power-on reset
    rb_hold = 1'b1;
    supply_ok_in = 1'b1;
    wait_ready();
    end_sim();
  end
endmodule : testbench
